// ==== core/tcif_pkg.sv ====
/*
 * Shared constants of the timer compare and interrupt flag block:
 * register offsets, flag bit positions, reset values, counter limits
 * and waveform mode encodings.
 * Assumes an APB slave with byte addresses and 32-bit data.
 */
package tcif_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FLAG_W = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BUS_W  = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0C;

    // ------------------------------------------------------------
    // Flag and mask bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_WRAP    = 0;
    localparam int unsigned BIT_MATCH_A = 1;
    localparam int unsigned BIT_MATCH_B = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] CMP_RST   = 8'h00;
    localparam logic [FLAG_W-1:0] MASK_RST  = 3'h0;
    localparam logic              FLAG_RST  = 1'b0;
    localparam logic [BUS_W-1:0]  RD_ZERO   = 32'h0000_0000;

    // ------------------------------------------------------------
    // Counter limits
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] CNT_MAX    = 8'hFF;
    localparam logic [DATA_W-1:0] CNT_BOTTOM = 8'h00;

    // ------------------------------------------------------------
    // Waveform mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_PC_FIXED  = 3'h1;
    localparam logic [2:0] MODE_CTC       = 3'h2;
    localparam logic [2:0] MODE_FAST_FIX  = 3'h3;
    localparam logic [2:0] MODE_PC_CMPA   = 3'h5;
    localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

endpackage : tcif_pkg

// ==== core/tcif_match.sv ====
/*
 * One compare channel: flags a match of the counter against a
 * compare value on a timer clock enable, unless blocked.
 * Assumes counter and enable come from logic on the same clock.
 */
`timescale 1ns/10ps
module tcif_match
    import tcif_pkg::*;
(
    // Timer side
    input  wire logic              timer_tick,
    input  wire logic              blocked,
    input  wire logic [DATA_W-1:0] counter_value,
    // Compare value
    input  wire logic [DATA_W-1:0] compare_value,
    // Result
    output logic                   hit
);

    // ------------------------------------------------------------
    // Equality compare, held off while blocked
    // ------------------------------------------------------------
    wire logic equal;

    assign equal = (counter_value == compare_value);
    assign hit   = timer_tick & ~blocked & equal;

endmodule : tcif_match

// ==== core/tcif_flag.sv ====
/*
 * One sticky interrupt flag: set by a hardware event, cleared by a
 * software write of one or by the interrupt vector being taken.
 * Assumes all inputs are one-cycle pulses on clk.
 */
`timescale 1ns/10ps
module tcif_flag
    import tcif_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Events
    input  wire logic set_evt,
    input  wire logic clr_sw,
    input  wire logic clr_vec,
    // State
    output logic      flag_q
);

    // ------------------------------------------------------------
    // Set wins over either clear
    // ------------------------------------------------------------
    wire logic flag_d;

    assign flag_d = set_evt | (flag_q & ~clr_sw & ~clr_vec);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule : tcif_flag

// ==== core/tcif_top.sv ====
/*
 * Compare and interrupt logic of an 8-bit timer: two compare
 * registers, interrupt mask, interrupt flags, APB register access.
 * Assumes the counter, its enable pulse, the mode select and the
 * vector acknowledges come from logic on clk; no synchronisers.
 */
`timescale 1ns/10ps
module tcif_top
    import tcif_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [BUS_W-1:0]  pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [BUS_W-1:0]  prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Counter unit
    input  wire logic [DATA_W-1:0] counter_value,
    input  wire logic              timer_tick,
    input  wire logic              counter_write,
    input  wire logic [2:0]        waveform_mode_sel,
    input  wire logic              force_match_a_strobe,
    input  wire logic              force_match_b_strobe,
    // CPU core
    input  wire logic              global_irq_en,
    input  wire logic              vector_taken_a,
    input  wire logic              vector_taken_b,
    input  wire logic              vector_taken_wrap,
    // Waveform generator
    output logic      [DATA_W-1:0] compare_a_value,
    output logic                   match_a_event,
    output logic                   match_b_event,
    // Interrupt requests
    output logic                   irq_req_a,
    output logic                   irq_req_b,
    output logic                   irq_req_wrap,
    output logic                   irq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] cmp_a_q;
    logic [DATA_W-1:0] cmp_b_q;
    logic [FLAG_W-1:0] mask_q;
    logic [FLAG_W-1:0] flags_q;
    logic              blk_q;
    logic [BUS_W-1:0]  prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic              match_a_q;
    logic              match_b_q;
    logic [FLAG_W-1:0] irq_req_q;
    logic              irq_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic              acc_phase;
    wire logic              acc_done;
    wire logic              wr_done;
    wire logic              lane0;
    wire logic              sel_cmp_a;
    wire logic              sel_cmp_b;
    wire logic              sel_mask;
    wire logic              sel_flags;
    wire logic              mapped;
    wire logic              wr_cmp_a;
    wire logic              wr_cmp_b;
    wire logic              wr_mask;
    wire logic              wr_flags;
    wire logic [BUS_W-1:0]  rd_data;

    // Answer one cycle into the access phase
    assign acc_phase = psel & penable;
    assign acc_done  = acc_phase & pready_q;
    assign wr_done   = acc_done & pwrite;
    assign lane0     = pstrb[0];

    assign sel_cmp_a = (paddr == OFS_CMP_A);
    assign sel_cmp_b = (paddr == OFS_CMP_B);
    assign sel_mask  = (paddr == OFS_MASK);
    assign sel_flags = (paddr == OFS_FLAGS);
    assign mapped    = sel_cmp_a | sel_cmp_b | sel_mask | sel_flags;

    assign wr_cmp_a  = wr_done & sel_cmp_a & lane0;
    assign wr_cmp_b  = wr_done & sel_cmp_b & lane0;
    assign wr_mask   = wr_done & sel_mask  & lane0;
    assign wr_flags  = wr_done & sel_flags & lane0;

    // Reserved mask and flag bits read as zero
    assign rd_data =
        sel_cmp_a ? {24'h00_0000, cmp_a_q} :
        sel_cmp_b ? {24'h00_0000, cmp_b_q} :
        sel_mask  ? {29'h0000_0000, mask_q} :
        sel_flags ? {29'h0000_0000, flags_q} :
                    RD_ZERO;

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    wire logic pready_d;

    assign pready_d = acc_phase & ~pready_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RD_ZERO;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pready_d & ~mapped;
            prdata_q  <= (pready_d & ~pwrite) ? rd_data : RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_a_q <= CMP_RST;
            cmp_b_q <= CMP_RST;
            mask_q  <= MASK_RST;
        end else begin
            if (wr_cmp_a) begin
                cmp_a_q <= pwdata[DATA_W-1:0];
            end
            if (wr_cmp_b) begin
                cmp_b_q <= pwdata[DATA_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[FLAG_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Match block after a counter write
    // ------------------------------------------------------------
    wire logic blk_d;

    // Held until the tick after the write has passed
    assign blk_d = counter_write | (blk_q & ~timer_tick);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= blk_d;
        end
    end

    // ------------------------------------------------------------
    // Compare channels
    // ------------------------------------------------------------
    wire logic hit_a;
    wire logic hit_b;

    tcif_match u_match_a (
        .timer_tick    (timer_tick),
        .blocked       (blk_q),
        .counter_value (counter_value),
        .compare_value (cmp_a_q),
        .hit           (hit_a)
    );

    tcif_match u_match_b (
        .timer_tick    (timer_tick),
        .blocked       (blk_q),
        .counter_value (counter_value),
        .compare_value (cmp_b_q),
        .hit           (hit_b)
    );

    // ------------------------------------------------------------
    // Wrap detection by mode
    // ------------------------------------------------------------
    wire logic at_max;
    wire logic at_bottom;
    wire logic at_top_a;
    wire logic mode_max;
    wire logic mode_bot;
    wire logic mode_top;
    wire logic hit_wrap;
    wire logic non_pwm;

    assign at_max    = (counter_value == CNT_MAX);
    assign at_bottom = (counter_value == CNT_BOTTOM);
    assign at_top_a  = (counter_value == cmp_a_q);

    assign mode_max = (waveform_mode_sel == MODE_NORMAL)
                    | (waveform_mode_sel == MODE_CTC)
                    | (waveform_mode_sel == MODE_FAST_FIX);
    assign mode_bot = (waveform_mode_sel == MODE_PC_FIXED)
                    | (waveform_mode_sel == MODE_PC_CMPA);
    assign mode_top = (waveform_mode_sel == MODE_FAST_CMPA);

    // Reserved modes never raise a wrap
    assign hit_wrap = timer_tick & ((mode_max & at_max)
                                  | (mode_bot & at_bottom)
                                  | (mode_top & at_top_a));

    assign non_pwm = (waveform_mode_sel == MODE_NORMAL)
                   | (waveform_mode_sel == MODE_CTC);

    // ------------------------------------------------------------
    // Waveform events
    // ------------------------------------------------------------
    wire logic match_a_d;
    wire logic match_b_d;

    // Force reaches the waveform only, in non-PWM modes
    assign match_a_d = hit_a | (force_match_a_strobe & non_pwm);
    assign match_b_d = hit_b | (force_match_b_strobe & non_pwm);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
        end else begin
            match_a_q <= match_a_d;
            match_b_q <= match_b_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    wire logic [FLAG_W-1:0] flag_set;
    wire logic [FLAG_W-1:0] flag_clr_sw;
    wire logic [FLAG_W-1:0] flag_clr_vec;

    assign flag_set[BIT_MATCH_B] = hit_b;
    assign flag_set[BIT_MATCH_A] = hit_a;
    assign flag_set[BIT_WRAP]    = hit_wrap;

    // Ones clear, zeros leave the flag alone
    assign flag_clr_sw = {FLAG_W{wr_flags}}
                       & pwdata[FLAG_W-1:0];

    assign flag_clr_vec[BIT_MATCH_B] = vector_taken_b;
    assign flag_clr_vec[BIT_MATCH_A] = vector_taken_a;
    assign flag_clr_vec[BIT_WRAP]    = vector_taken_wrap;

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
            tcif_flag u_flag (
                .clk     (clk),
                .rst_n   (rst_n),
                .set_evt (flag_set[gi]),
                .clr_sw  (flag_clr_sw[gi]),
                .clr_vec (flag_clr_vec[gi]),
                .flag_q  (flags_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    wire logic [FLAG_W-1:0] pending;
    wire logic [FLAG_W-1:0] irq_req_d;

    assign pending   = flags_q & mask_q;
    assign irq_req_d = pending & {FLAG_W{global_irq_en}};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_req_q <= MASK_RST;
            irq_q     <= 1'b0;
        end else begin
            irq_req_q <= irq_req_d;
            irq_q     <= |pending;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign compare_a_value = cmp_a_q;
    assign match_a_event   = match_a_q;
    assign match_b_event   = match_b_q;
    assign irq_req_b       = irq_req_q[BIT_MATCH_B];
    assign irq_req_a       = irq_req_q[BIT_MATCH_A];
    assign irq_req_wrap    = irq_req_q[BIT_WRAP];
    assign irq             = irq_q;

endmodule : tcif_top

// ==== tb/tcif_props.sv ====
/*
 * Port checks of the timer compare and interrupt flag block.
 * Assumes a bind to tcif_top; one clock, synchronous reset.
 */
`timescale 1ns/10ps
module tcif_props
    import tcif_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [BUS_W-1:0]  prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Timer side
    input wire logic [DATA_W-1:0] counter_value,
    input wire logic              timer_tick,
    input wire logic              counter_write,
    input wire logic              force_match_a_strobe,
    input wire logic              global_irq_en,
    input wire logic              vector_taken_a,
    // Results
    input wire logic [DATA_W-1:0] compare_a_value,
    input wire logic              match_a_event,
    input wire logic              irq_req_a,
    input wire logic              irq_req_b,
    input wire logic              irq_req_wrap,
    input wire logic              irq
);
    // --------------------
    // Tick after a counter write
    // --------------------
    logic blk_q;
    logic blk_d;
    assign blk_d = counter_write ? 1'b1 : (timer_tick ? 1'b0 : blk_q);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= blk_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // --------------------
    // Assertions
    // --------------------
    AST_PREADY_WAIT: assert property (
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not on second access cycle");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (
        pready && paddr > OFS_FLAGS |-> pslverr && prdata == RD_ZERO)
        else $error("unmapped access not refused");
    AST_MASK_RES: assert property (
        pready && !pwrite && paddr == OFS_MASK |-> prdata[31:3] == '0)
        else $error("mask upper bits not zero");
    AST_FLAG_RES: assert property (
        pready && !pwrite && paddr == OFS_FLAGS |-> prdata[31:3] == '0)
        else $error("flag upper bits not zero");
    AST_HIT_A: assert property (
        timer_tick && !blk_q && counter_value == compare_a_value
        |=> match_a_event)
        else $error("compare A hit without event");
    AST_BLOCK_A: assert property (
        timer_tick && blk_q && !force_match_a_strobe |=> !match_a_event)
        else $error("hit not blocked after counter write");
    AST_GATE: assert property (
        !global_irq_en |=> !(irq_req_a || irq_req_b || irq_req_wrap))
        else $error("request without global enable");
    AST_IRQ_OR: assert property (
        irq_req_a || irq_req_b || irq_req_wrap |-> irq)
        else $error("request without irq");
    AST_VEC_CLR: assert property (
        vector_taken_a && !timer_tick |=> ##1 !irq_req_a)
        else $error("vector did not clear request A");
endmodule : tcif_props

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the timer compare and interrupt block.
 * Assumes tcif_top and tcif_props compiled; drives all inputs.
 */
`timescale 1ns/10ps
module testbench
    import tcif_pkg::*;
;
    logic        clk;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  counter_value = 8'h00;
    logic        timer_tick = 1'b0;
    logic        counter_write = 1'b0;
    logic [2:0]  waveform_mode_sel = 3'h0;
    logic [1:0]  frc = 2'h0;
    logic        global_irq_en = 1'b0;
    logic [2:0]  vt = 3'h0;
    logic [7:0]  compare_a_value;
    logic        match_a_event;
    logic        match_b_event;
    logic [2:0]  reqs;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [7:0]  cv [8] = '{8'hFF, 8'h00, 8'hFF, 8'hFF,
                            8'hFF, 8'h00, 8'hFF, 8'h5A};
    logic [2:0]  fe [8] = '{3'h1, 3'h1, 3'h1, 3'h1,
                            3'h0, 3'h1, 3'h0, 3'h3};
    logic [7:0]  ic [3] = '{8'hFF, 8'h5A, 8'hA5};

    tcif_top uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_write(counter_write),
        .waveform_mode_sel(waveform_mode_sel),
        .force_match_a_strobe(frc[0]), .force_match_b_strobe(frc[1]),
        .global_irq_en(global_irq_en), .vector_taken_a(vt[1]),
        .vector_taken_b(vt[2]), .vector_taken_wrap(vt[0]),
        .compare_a_value(compare_a_value), .match_a_event(match_a_event),
        .match_b_event(match_b_event), .irq_req_a(reqs[1]),
        .irq_req_b(reqs[2]), .irq_req_wrap(reqs[0]), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rd

    task automatic tick(input logic [7:0] v);
        @(posedge clk);
        counter_value <= v;
        timer_tick <= 1'b1;
        @(posedge clk);
        timer_tick <= 1'b0;
    endtask : tick

    // --------------------
    // Tests
    // --------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CMP_A, 32'h0, "cmp_a");
        rd(OFS_MASK, 32'h0, "mask");
        rd(OFS_FLAGS, 32'h0, "flags");
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
        chk("unmapped", 32'h0, rdat);
        $display("test reset ended");
        wr(OFS_CMP_A, 32'hFFFF_FF5A);
        wr(OFS_CMP_B, 32'h1234_56A5);
        wr(OFS_MASK, 32'hFFFF_FFFF);
        rd(OFS_CMP_A, 32'h5A, "cmp_a");
        rd(OFS_CMP_B, 32'hA5, "cmp_b");
        rd(OFS_MASK, 32'h7, "mask");
        chk("cmp_a port", 32'h5A, {24'h0, compare_a_value});
        $display("test registers ended");
        tick(8'h5A);
        @(negedge clk);
        chk("match_a_event", 32'h1, {31'h0, match_a_event});
        rd(OFS_FLAGS, 32'h2, "flags");
        tick(8'hA5);
        @(negedge clk);
        chk("match_b_event", 32'h1, {31'h0, match_b_event});
        rd(OFS_FLAGS, 32'h6, "flags");
        wr(OFS_FLAGS, 32'h2);
        rd(OFS_FLAGS, 32'h4, "flags");
        wr(OFS_FLAGS, 32'h4);
        for (int i = 0; i < 8; i++) begin
            waveform_mode_sel <= 3'(i);
            tick(cv[i]);
            rd(OFS_FLAGS, {29'h0, fe[i]}, "wrap flags");
            wr(OFS_FLAGS, 32'h0);
            rd(OFS_FLAGS, {29'h0, fe[i]}, "kept flags");
            wr(OFS_FLAGS, 32'hFF);
            rd(OFS_FLAGS, 32'h0, "cleared flags");
        end
        $display("test flags ended");
        waveform_mode_sel <= MODE_NORMAL;
        @(posedge clk);
        counter_write <= 1'b1;
        @(posedge clk);
        counter_write <= 1'b0;
        tick(8'h5A);
        rd(OFS_FLAGS, 32'h0, "blocked flags");
        tick(8'h5A);
        rd(OFS_FLAGS, 32'h2, "flags");
        @(posedge clk);
        timer_tick <= 1'b1;
        vt <= 3'h2;
        @(posedge clk);
        timer_tick <= 1'b0;
        vt <= 3'h0;
        rd(OFS_FLAGS, 32'h2, "set over clear");
        wr(OFS_FLAGS, 32'h7);
        $display("test block ended");
        wr(OFS_MASK, 32'h7);
        for (int b = 0; b < 3; b++) begin
            tick(ic[b]);
            repeat (2) @(negedge clk);
            chk("gated req", 32'h0, {29'h0, reqs});
            chk("irq", 32'h1, {31'h0, irq});
            @(posedge clk);
            global_irq_en <= 1'b1;
            repeat (2) @(negedge clk);
            chk("req", 32'h1 << b, {29'h0, reqs});
            @(posedge clk);
            vt <= 3'(1 << b);
            @(posedge clk);
            vt <= 3'h0;
            rd(OFS_FLAGS, 32'h0, "vector flags");
            chk("irq", 32'h0, {31'h0, irq});
            global_irq_en <= 1'b0;
        end
        global_irq_en <= 1'b1;
        wr(OFS_MASK, 32'h5);
        tick(8'h5A);
        repeat (2) @(negedge clk);
        chk("masked req", 32'h0, {29'h0, reqs});
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(OFS_FLAGS, 32'h7);
        $display("test interrupts ended");
        for (int i = 0; i < 2; i++) begin
            waveform_mode_sel <= 3'(i * 3);
            @(posedge clk);
            frc <= 2'h3;
            @(posedge clk);
            frc <= 2'h0;
            @(negedge clk);
            chk("force events", (i == 0) ? 32'h3 : 32'h0,
                {30'h0, match_b_event, match_a_event});
            rd(OFS_FLAGS, 32'h0, "forced flags");
        end
        $display("test force ended");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule : testbench

bind tcif_top tcif_props u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value),
    .timer_tick(timer_tick), .counter_write(counter_write),
    .force_match_a_strobe(force_match_a_strobe),
    .global_irq_en(global_irq_en), .vector_taken_a(vector_taken_a),
    .compare_a_value(compare_a_value), .match_a_event(match_a_event),
    .irq_req_a(irq_req_a), .irq_req_b(irq_req_b),
    .irq_req_wrap(irq_req_wrap), .irq(irq)
);
